/* tpio_pkg.sv */
// Constants, mode type and decode helpers for the timer pin control block
package tpio_pkg;

    // ****************************************
    // Register map and layout
    // ****************************************
    localparam logic [3:0] ADDR_CH2_IO_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CH3_IO_CONTROL_HIGH = 4'h1;
    localparam logic [3:0] ADDR_CH3_IO_CONTROL_LOW = 4'h2;
    localparam logic [3:0] ADDR_CH3_MODE_REG = 4'h3;
    localparam logic [3:0] ADDR_CH2_GENERAL_REG_A = 4'h4;
    localparam logic [3:0] ADDR_CH3_GENERAL_REG_A = 4'h5;
    localparam logic [3:0] ADDR_CH3_GENERAL_REG_C = 4'h6;
    localparam logic [3:0] ADDR_EVENT_STATUS = 4'h7;
    localparam logic [3:0] ADDR_EVENT_MASK = 4'h8;

    localparam logic [7:0] IO_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_REG_RESET = 8'h00;
    localparam logic [15:0] GENERAL_REG_RESET = 16'hFFFF;
    localparam logic [2:0] EVENT_RESET = 3'h0;

    localparam int BUFFER_A_ENABLE_POS = 4;
    localparam int CODE_DIR_POS = 3;
    localparam int CODE_LEVEL_POS = 2;
    localparam int EVT_CH2_A = 0;
    localparam int EVT_CH3_A = 1;
    localparam int EVT_CH3_C = 2;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [2:0] {
        TPIO_COMPARE = 3'h1,
        TPIO_CAPTURE_PIN = 3'h2,
        TPIO_CAPTURE_ALT = 3'h4
    } tpio_mode_type;

    function automatic tpio_mode_type tpio_decode_mode(input logic [3:0] code, input logic alt_ok);
        tpio_mode_type m;
        m = TPIO_COMPARE;
        if (code[CODE_DIR_POS]) begin
            m = (code[CODE_LEVEL_POS] && alt_ok) ? TPIO_CAPTURE_ALT : TPIO_CAPTURE_PIN;
        end
        return m;
    endfunction

    // Bit 1 set means both edges, bit 0 then ignored
    function automatic logic tpio_edge_hit(input logic [1:0] low, input logic rise, input logic fall);
        logic hit;
        hit = 1'b0;
        if (low[1]) begin
            hit = rise | fall;
        end else if (low[0]) begin
            hit = fall;
        end else begin
            hit = rise;
        end
        return hit;
    endfunction

endpackage

/* tpio_sync.sv */
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module tpio_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin_async,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Only the later two stages vote, first stage may be metastable
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule // tpio_sync
`default_nettype wire

/* tpio_pin_unit.sv */
// Compare and capture logic for one general register and its pin
`timescale 1ns/1ps
`default_nettype none
module tpio_pin_unit (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] code,
    input wire logic code_load,
    input wire logic alt_ok,
    input wire logic pin_level,
    input wire logic alt_step,
    input wire logic inhibit,
    input wire logic [15:0] count,
    input wire logic [15:0] gen_reg,
    output logic pin_out_q,
    output logic pin_oe_n,
    output logic capture_q,
    output logic compare_q
);
    tpio_pkg::tpio_mode_type mode;
    logic level_prev_q;
    logic equal_prev_q;
    logic rise;
    logic fall;
    logic equal;
    logic cap_hit;
    logic match_hit;

    assign mode = tpio_pkg::tpio_decode_mode(code, alt_ok);
    assign rise = pin_level & ~level_prev_q;
    assign fall = ~pin_level & level_prev_q;
    assign equal = (count == gen_reg);
    assign cap_hit = !inhibit && ((mode == tpio_pkg::TPIO_CAPTURE_PIN && tpio_pkg::tpio_edge_hit(code[1:0], rise, fall))
        || (mode == tpio_pkg::TPIO_CAPTURE_ALT && alt_step)); // R9 R10 R11 R12 R13 R14
    // Fires on entry to equality so a stalled counter matches once
    assign match_hit = !inhibit && mode == tpio_pkg::TPIO_COMPARE && equal && !equal_prev_q; // R15 R14
    assign pin_oe_n = !(mode == tpio_pkg::TPIO_COMPARE && code[1:0] != 2'h0 && !inhibit); // R1 R2

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_prev_q <= 1'b0;
            equal_prev_q <= 1'b0;
        end else begin
            level_prev_q <= pin_level;
            equal_prev_q <= equal;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_out_q <= 1'b0;
        end else if (code_load && mode == tpio_pkg::TPIO_COMPARE) begin
            pin_out_q <= code[tpio_pkg::CODE_LEVEL_POS]; // R16 R1 R2
        end else if (match_hit) begin
            case (code[1:0])
                2'h1: pin_out_q <= 1'b0; // R3
                2'h2: pin_out_q <= 1'b1; // R4
                2'h3: pin_out_q <= ~pin_out_q; // R5
                default: pin_out_q <= pin_out_q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            capture_q <= 1'b0;
            compare_q <= 1'b0;
        end else begin
            capture_q <= cap_hit;
            compare_q <= match_hit;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_match(logic [1:0] low);
        match_hit && !code_load && code[1:0] == low;
    endsequence

    property p_match_low;
        s_match(2'h1) |=> !pin_out_q;
    endproperty
    a_match_low: assert property (p_match_low) else $error("pin not low after match"); // R3

    property p_match_high;
        s_match(2'h2) |=> pin_out_q;
    endproperty
    a_match_high: assert property (p_match_high) else $error("pin not high after match"); // R4

    property p_match_toggle;
        s_match(2'h3) |=> pin_out_q != $past(pin_out_q);
    endproperty
    a_match_toggle: assert property (p_match_toggle) else $error("pin not toggled"); // R5

    property p_disable;
        (!code[3] && code[1:0] == 2'h0) |-> pin_oe_n;
    endproperty
    a_disable: assert property (p_disable) else $error("output enabled with low bits zero"); // R1

    property p_rise;
        (mode == tpio_pkg::TPIO_CAPTURE_PIN && !inhibit && code[1:0] == 2'h0 && pin_level && !level_prev_q)
            |=> capture_q;
    endproperty
    a_rise: assert property (p_rise) else $error("no capture on rising edge"); // R9

    property p_fall;
        (mode == tpio_pkg::TPIO_CAPTURE_PIN && code[1:0] == 2'h1 && pin_level && !level_prev_q) |=> !capture_q;
    endproperty
    a_fall: assert property (p_fall) else $error("capture on rising edge in falling mode"); // R10

    property p_both;
        (mode == tpio_pkg::TPIO_CAPTURE_PIN && !inhibit && code[1] && pin_level != level_prev_q) |=> capture_q;
    endproperty
    a_both: assert property (p_both) else $error("no capture on edge in both-edge mode"); // R11
endmodule // tpio_pin_unit
`default_nettype wire

/* tpio_top.sv */
// Timer pin input/output control for channel 2 register A and channel 3 registers A and C
//
// Summary of operation
// [R1] Compare mode, bit 2 clear: initial low
// [R2] Compare mode, bit 2 set: initial high
// [R3] Low bits 01: pin low on match
// [R4] Low bits 10: pin high on match
// [R5] Low bits 11: pin toggles on match
// [R6] Channel 3 register A captures from pin A
// [R7] Channel 3 register C captures from pin C
// [R8] Channel 2 register A captures from its pin
// [R9] Low bits 00: capture on rising edge
// [R10] Low bits 01: capture on falling edge
// [R11] Bit 1 set: capture on both edges
// [R12] Code 11xx on channel 3 registers: channel 4 count is source
// [R13] Capture on each channel 4 count step
// [R14] Buffer mode blocks register C events
// [R15] Capture copies counter; match on equality
// [R16] Initial level applied when code written
`timescale 1ns/1ps
`default_nettype none
module tpio_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    input wire logic [15:0] ch2_count,
    input wire logic [15:0] ch3_count,
    input wire logic ch4_count_step,
    input wire logic ch2_pin_a_in,
    output logic ch2_pin_a_out,
    output logic ch2_pin_a_oe_n,
    input wire logic ch3_pin_a_in,
    output logic ch3_pin_a_out,
    output logic ch3_pin_a_oe_n,
    input wire logic ch3_pin_c_in,
    output logic ch3_pin_c_out,
    output logic ch3_pin_c_oe_n
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] ch2_io_control_q;
    logic [7:0] ch3_io_control_high_q;
    logic [7:0] ch3_io_control_low_q;
    logic [7:0] ch3_mode_reg_q;
    logic [15:0] ch2_general_reg_a_q;
    logic [15:0] ch3_general_reg_a_q;
    logic [15:0] ch3_general_reg_c_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [15:0] rdata_q;
    logic load_ch2_q;
    logic load_ch3_a_q;
    logic load_ch3_c_q;
    logic ch2_level;
    logic ch3_a_level;
    logic ch3_c_level;
    logic ch2_cap;
    logic ch3_a_cap;
    logic ch3_c_cap;
    logic ch2_cmp;
    logic ch3_a_cmp;
    logic ch3_c_cmp;
    logic buffer_a_enable;
    logic [2:0] events;
    logic wr_ch2_ctl;
    logic wr_ch3_high;
    logic wr_ch3_low;

    function automatic logic hit(input logic strobe, input logic [3:0] addr, input logic [3:0] target);
        return strobe && addr == target;
    endfunction

    assign wr_ch2_ctl = hit(reg_wr, reg_addr, tpio_pkg::ADDR_CH2_IO_CONTROL);
    assign wr_ch3_high = hit(reg_wr, reg_addr, tpio_pkg::ADDR_CH3_IO_CONTROL_HIGH);
    assign wr_ch3_low = hit(reg_wr, reg_addr, tpio_pkg::ADDR_CH3_IO_CONTROL_LOW);
    assign buffer_a_enable = ch3_mode_reg_q[tpio_pkg::BUFFER_A_ENABLE_POS];

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ch2_io_control_q <= tpio_pkg::IO_CONTROL_RESET;
            ch3_io_control_high_q <= tpio_pkg::IO_CONTROL_RESET;
            ch3_io_control_low_q <= tpio_pkg::IO_CONTROL_RESET;
            ch3_mode_reg_q <= tpio_pkg::MODE_REG_RESET;
            mask_q <= tpio_pkg::EVENT_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                tpio_pkg::ADDR_CH2_IO_CONTROL: ch2_io_control_q <= reg_wdata[7:0];
                tpio_pkg::ADDR_CH3_IO_CONTROL_HIGH: ch3_io_control_high_q <= reg_wdata[7:0];
                tpio_pkg::ADDR_CH3_IO_CONTROL_LOW: ch3_io_control_low_q <= reg_wdata[7:0];
                tpio_pkg::ADDR_CH3_MODE_REG: ch3_mode_reg_q <= reg_wdata[7:0];
                tpio_pkg::ADDR_EVENT_MASK: mask_q <= reg_wdata[2:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    // One-cycle load pulse so the unit sees the new code already stored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            load_ch2_q <= 1'b0;
            load_ch3_a_q <= 1'b0;
            load_ch3_c_q <= 1'b0;
        end else begin
            load_ch2_q <= wr_ch2_ctl; // R16
            load_ch3_a_q <= wr_ch3_high; // R16
            load_ch3_c_q <= wr_ch3_low; // R16
        end
    end

    // ****************************************
    // General registers
    // ****************************************
    // Capture beats a software write in the same cycle: the hardware value is newer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ch2_general_reg_a_q <= tpio_pkg::GENERAL_REG_RESET;
        end else if (ch2_cap) begin
            ch2_general_reg_a_q <= ch2_count; // R15 R8
        end else if (hit(reg_wr, reg_addr, tpio_pkg::ADDR_CH2_GENERAL_REG_A)) begin
            ch2_general_reg_a_q <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ch3_general_reg_a_q <= tpio_pkg::GENERAL_REG_RESET;
        end else if (ch3_a_cap) begin
            ch3_general_reg_a_q <= ch3_count; // R15 R6 R13
        end else if (hit(reg_wr, reg_addr, tpio_pkg::ADDR_CH3_GENERAL_REG_A)) begin
            ch3_general_reg_a_q <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ch3_general_reg_c_q <= tpio_pkg::GENERAL_REG_RESET;
        end else if (ch3_c_cap) begin
            ch3_general_reg_c_q <= ch3_count; // R15 R7 R13
        end else if (hit(reg_wr, reg_addr, tpio_pkg::ADDR_CH3_GENERAL_REG_C)) begin
            ch3_general_reg_c_q <= reg_wdata;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    tpio_sync u_sync_ch2_a (
        .clock(clock),
        .rstn(rstn),
        .pin_async(ch2_pin_a_in),
        .level_q(ch2_level)
    );

    tpio_sync u_sync_ch3_a (
        .clock(clock),
        .rstn(rstn),
        .pin_async(ch3_pin_a_in),
        .level_q(ch3_a_level)
    );

    tpio_sync u_sync_ch3_c (
        .clock(clock),
        .rstn(rstn),
        .pin_async(ch3_pin_c_in),
        .level_q(ch3_c_level)
    );

    // ****************************************
    // Compare and capture units
    // ****************************************
    // Channel 2 has no alternate source: code 11xx still captures from the pin
    tpio_pin_unit u_ch2_a (
        .clock(clock),
        .rstn(rstn),
        .code(ch2_io_control_q[3:0]),
        .code_load(load_ch2_q),
        .alt_ok(1'b0),
        .pin_level(ch2_level), // R8
        .alt_step(1'b0),
        .inhibit(1'b0),
        .count(ch2_count),
        .gen_reg(ch2_general_reg_a_q),
        .pin_out_q(ch2_pin_a_out),
        .pin_oe_n(ch2_pin_a_oe_n),
        .capture_q(ch2_cap),
        .compare_q(ch2_cmp)
    );

    tpio_pin_unit u_ch3_a (
        .clock(clock),
        .rstn(rstn),
        .code(ch3_io_control_high_q[3:0]),
        .code_load(load_ch3_a_q),
        .alt_ok(1'b1), // R12
        .pin_level(ch3_a_level), // R6
        .alt_step(ch4_count_step), // R13
        .inhibit(1'b0),
        .count(ch3_count),
        .gen_reg(ch3_general_reg_a_q),
        .pin_out_q(ch3_pin_a_out),
        .pin_oe_n(ch3_pin_a_oe_n),
        .capture_q(ch3_a_cap),
        .compare_q(ch3_a_cmp)
    );

    tpio_pin_unit u_ch3_c (
        .clock(clock),
        .rstn(rstn),
        .code(ch3_io_control_low_q[3:0]),
        .code_load(load_ch3_c_q),
        .alt_ok(1'b1), // R12
        .pin_level(ch3_c_level), // R7
        .alt_step(ch4_count_step), // R13
        .inhibit(buffer_a_enable), // R14
        .count(ch3_count),
        .gen_reg(ch3_general_reg_c_q),
        .pin_out_q(ch3_pin_c_out),
        .pin_oe_n(ch3_pin_c_oe_n),
        .capture_q(ch3_c_cap),
        .compare_q(ch3_c_cmp)
    );

    // ****************************************
    // Event status and interrupt
    // ****************************************
    assign events[tpio_pkg::EVT_CH2_A] = ch2_cap | ch2_cmp;
    assign events[tpio_pkg::EVT_CH3_A] = ch3_a_cap | ch3_a_cmp;
    assign events[tpio_pkg::EVT_CH3_C] = ch3_c_cap | ch3_c_cmp;

    // Set wins over read-to-clear so no event is lost
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_q <= tpio_pkg::EVENT_RESET;
        end else if (hit(reg_rd, reg_addr, tpio_pkg::ADDR_EVENT_STATUS)) begin
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    assign irq = |(status_q & mask_q);

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                tpio_pkg::ADDR_CH2_IO_CONTROL: rdata_q <= {8'h00, ch2_io_control_q};
                tpio_pkg::ADDR_CH3_IO_CONTROL_HIGH: rdata_q <= {8'h00, ch3_io_control_high_q};
                tpio_pkg::ADDR_CH3_IO_CONTROL_LOW: rdata_q <= {8'h00, ch3_io_control_low_q};
                tpio_pkg::ADDR_CH3_MODE_REG: rdata_q <= {8'h00, ch3_mode_reg_q};
                tpio_pkg::ADDR_CH2_GENERAL_REG_A: rdata_q <= ch2_general_reg_a_q;
                tpio_pkg::ADDR_CH3_GENERAL_REG_A: rdata_q <= ch3_general_reg_a_q;
                tpio_pkg::ADDR_CH3_GENERAL_REG_C: rdata_q <= ch3_general_reg_c_q;
                tpio_pkg::ADDR_EVENT_STATUS: rdata_q <= {13'h0000, status_q};
                tpio_pkg::ADDR_EVENT_MASK: rdata_q <= {13'h0000, mask_q};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_code_write(logic wr, logic [3:0] code);
        wr && !code[3] && code[1:0] != 2'h0;
    endsequence

    property p_init_low;
        s_code_write(wr_ch3_high, reg_wdata[3:0]) ##0 !reg_wdata[2] ##2 1'b1 |-> !ch3_pin_a_out && !ch3_pin_a_oe_n;
    endproperty
    a_init_low: assert property (p_init_low) else $error("initial low level not applied"); // R1 R16

    property p_init_high;
        s_code_write(wr_ch3_low, reg_wdata[3:0]) ##0 reg_wdata[2] ##2 !buffer_a_enable |-> ch3_pin_c_out;
    endproperty
    a_init_high: assert property (p_init_high) else $error("initial high level not applied"); // R2 R16

    property p_ch2_capture;
        ch2_cap |=> ch2_general_reg_a_q == $past(ch2_count);
    endproperty
    a_ch2_capture: assert property (p_ch2_capture) else $error("capture did not load counter"); // R15 R8

    sequence s_ch4_step;
        ch3_io_control_high_q[3:2] == 2'h3 && ch4_count_step;
    endsequence

    property p_ch4_capture;
        s_ch4_step |=> ##1 ch3_general_reg_a_q == $past(ch3_count);
    endproperty
    a_ch4_capture: assert property (p_ch4_capture) else $error("no capture on channel 4 step"); // R12 R13

    property p_ch4_ignores_pin;
        (ch3_io_control_high_q[3:2] == 2'h3 && !ch4_count_step && !reg_wr) |=> !ch3_a_cap;
    endproperty
    a_ch4_ignores_pin: assert property (p_ch4_ignores_pin) else $error("pin capture in count source mode"); // R12

    property p_buffer_block;
        buffer_a_enable [*2] |-> !ch3_c_cap && !ch3_c_cmp;
    endproperty
    a_buffer_block: assert property (p_buffer_block) else $error("register C event while buffered"); // R14

    property p_c_from_pin;
        (tpio_pkg::tpio_decode_mode(ch3_io_control_low_q[3:0], 1'b1) == tpio_pkg::TPIO_CAPTURE_PIN
            && ch3_io_control_low_q[1] && !buffer_a_enable && $changed(ch3_c_level)) |=> ch3_c_cap;
    endproperty
    a_c_from_pin: assert property (p_c_from_pin) else $error("register C missed pin edge"); // R7

    property p_a_from_pin;
        (tpio_pkg::tpio_decode_mode(ch3_io_control_high_q[3:0], 1'b1) == tpio_pkg::TPIO_CAPTURE_PIN
            && ch3_io_control_high_q[1] && $changed(ch3_a_level)) |=> ch3_a_cap;
    endproperty
    a_a_from_pin: assert property (p_a_from_pin) else $error("register A missed pin edge"); // R6

    property p_irq;
        (|(events & mask_q) && !(reg_wr && reg_addr == tpio_pkg::ADDR_EVENT_MASK)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in event gave no interrupt"); // R15
endmodule // tpio_top
`default_nettype wire

/* tpio_pin_model.sv */
// Partner model of the external timer pins
`timescale 1ns/1ps
`default_nettype none
module tpio_pin_model (
    input wire logic [2:0] ext_level,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    output logic [2:0] pin_in
);
    // ****************************************
    // Wire level
    // ****************************************
    // Block wins while its enable is low, so pin reads back its own drive
    assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule // tpio_pin_model
`default_nettype wire

/* tpio_top_tb.sv */
// Self-checking bench for the timer pin control block
`timescale 1ns/1ps
`default_nettype none
module tpio_top_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    logic [15:0] ch2_count = 16'h0000;
    logic [15:0] ch3_count = 16'h0000;
    logic ch4_count_step = 1'b0;
    logic [2:0] ext_level = 3'h0;
    logic [2:0] pin_in;
    logic [2:0] pin_out;
    logic [2:0] pin_oe_n;
    integer seed = 32'haa68;
    int bad_count = 0;
    int n_checks = 0;
    logic [15:0] rd_q;
    logic [15:0] v;
    logic [15:0] old;
    logic [3:0] c;

    tpio_top tpio_top_i (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .ch2_count(ch2_count),
        .ch3_count(ch3_count), .ch4_count_step(ch4_count_step), .ch2_pin_a_in(pin_in[0]),
        .ch2_pin_a_out(pin_out[0]), .ch2_pin_a_oe_n(pin_oe_n[0]), .ch3_pin_a_in(pin_in[1]),
        .ch3_pin_a_out(pin_out[1]), .ch3_pin_a_oe_n(pin_oe_n[1]), .ch3_pin_c_in(pin_in[2]),
        .ch3_pin_c_out(pin_out[2]), .ch3_pin_c_oe_n(pin_oe_n[2]));
    tpio_pin_model tpio_pin_model_i (.ext_level(ext_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_in(pin_in));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic exp_match(input logic [3:0] code);
        return (code[1:0] == 2'b01) ? 1'b0 : (code[1:0] == 2'b10) ? 1'b1 : ~code[2];
    endfunction
    function automatic logic exp_hit(input int cl, input logic rise);
        return (cl == 0) ? rise : (cl == 1) ? ~rise : 1'b1;
    endfunction

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            rd(4'(a));
            chk("reset", rd_q, (a >= 4 && a <= 6) ? 16'hFFFF : 16'h0000);
        end
        v = 16'($random(seed)) & 16'h00EF;
        wr(tpio_pkg::ADDR_CH3_MODE_REG, v);
        wr(4'h9, 16'h00FF);
        rd(tpio_pkg::ADDR_CH3_MODE_REG);
        chk("mode", rd_q, v);
        rd(4'h9);
        chk("unmapped", rd_q, 16'h0000);
        wr(tpio_pkg::ADDR_CH3_MODE_REG, 16'h0000);
        // Compare codes 1 to 7 on every pin
        for (int ch = 0; ch < 3; ch++) begin
            for (int k = 1; k < 8; k++) begin
                v = 16'($random(seed)) | 16'h0001;
                c = 4'(k);
                ch2_count <= v - 16'h0001;
                ch3_count <= v - 16'h0001;
                wr(4'h4 + 4'(ch), v);
                wr(4'(ch), {12'h000, c});
                ticks(2);
                chk("oe_n", 16'(pin_oe_n[ch]), 16'(c[1:0] == 2'b00));
                if (c[1:0] != 2'b00) chk("init", 16'(pin_out[ch]), 16'(c[2]));
                ch2_count <= v;
                ch3_count <= v;
                ticks(3);
                if (c[1:0] != 2'b00) chk("match", 16'(pin_out[ch]), 16'(exp_match(c)));
            end
        end
        // Every capture edge code on every pin
        for (int ch = 0; ch < 3; ch++) begin
            for (int cl = 0; cl < 4; cl++) begin
                wr(4'(ch), 16'h0008 | 16'(cl) | ((ch == 0 && cl == 3) ? 16'h0004 : 16'h0000));
                for (int e = 0; e < 2; e++) begin
                    rd(tpio_pkg::ADDR_EVENT_STATUS);
                    v = 16'($random(seed));
                    ch2_count <= v;
                    ch3_count <= v;
                    ext_level[ch] <= (e == 0);
                    ticks(8);
                    rd(tpio_pkg::ADDR_EVENT_STATUS);
                    chk("cap_evt", rd_q & (16'h0001 << ch), exp_hit(cl, e == 0) ? 16'h0001 << ch : 16'h0000);
                    rd(4'h4 + 4'(ch));
                    if (exp_hit(cl, e == 0)) chk("cap_val", rd_q, v);
                end
            end
        end
        // Count-step capture, buffer inhibit and interrupt
        for (int b = 1; b >= 0; b--) begin
            wr(tpio_pkg::ADDR_CH3_MODE_REG, b ? 16'h0010 : 16'h0000);
            wr(tpio_pkg::ADDR_CH3_IO_CONTROL_LOW, b ? 16'h0005 : 16'h000C);
            ticks(2);
            if (b) chk("buf_oe_n", 16'(pin_oe_n[2]), 16'h0001);
            wr(tpio_pkg::ADDR_CH3_IO_CONTROL_LOW, 16'h000C);
            wr(tpio_pkg::ADDR_CH3_IO_CONTROL_HIGH, 16'h000F);
            wr(tpio_pkg::ADDR_EVENT_MASK, b ? 16'h0002 : 16'h0000);
            rd(tpio_pkg::ADDR_CH3_GENERAL_REG_C);
            old = rd_q;
            rd(tpio_pkg::ADDR_EVENT_STATUS);
            v = 16'($random(seed));
            ch3_count <= v;
            @(posedge clock);
            ch4_count_step <= 1'b1;
            @(posedge clock);
            ch4_count_step <= 1'b0;
            ticks(3);
            chk("irq", 16'(irq), 16'(b));
            rd(tpio_pkg::ADDR_CH3_GENERAL_REG_A);
            chk("step_a", rd_q, v);
            rd(tpio_pkg::ADDR_CH3_GENERAL_REG_C);
            chk("step_c", rd_q, b ? old : v);
            rd(tpio_pkg::ADDR_EVENT_STATUS);
            chk("step_evt", rd_q, b ? 16'h0002 : 16'h0006);
            chk("irq_clr", 16'(irq), 16'h0000);
        end
        print_verdict();
    end
endmodule // tpio_top_tb
`default_nettype wire
